//--- hdl/timer_counter_map.vh
// Register offsets, field positions, reset values and encodings of the timer/counter.
`ifndef TIMER_COUNTER_MAP_VH
`define TIMER_COUNTER_MAP_VH
// Register byte addresses on the Avalon-MM word bus (word index times four).
`define ADDR_COUNT_LOW     5'h00
`define ADDR_HIGH_BUFFER   5'h04
`define ADDR_CONTROL_ZERO  5'h08
`define ADDR_CONTROL_ONE   5'h0c
`define ADDR_IRQ           5'h10
// Control zero fields.
`define CTRL0_ENABLE_BIT   7
`define CTRL0_OUT_BIT      5
`define CTRL0_WIDE_BIT     4
`define CTRL0_POST_HI      3
`define CTRL0_POST_LO      0
// Control one fields.
`define CTRL1_CS_HI        7
`define CTRL1_CS_LO        5
`define CTRL1_ASYNC_BIT    4
`define CTRL1_PRE_HI       3
`define CTRL1_PRE_LO       0
// Interrupt register fields.
`define IRQ_FLAG_BIT       0
`define IRQ_ENABLE_BIT     1
// Reset values.
`define RST_COUNT_LOW      8'h00
`define RST_PERIOD         8'hff
`define RST_CONTROL        8'h00
// Clock source encodings.
`define CS_PIN_TRUE        3'h0
`define CS_PIN_INV         3'h1
`define CS_INSTR           3'h2
`define CS_HF_OSC          3'h3
`define CS_LF_OSC          3'h4
`define CS_RESERVED        3'h5
`define CS_SEC_OSC         3'h6
`define CS_LOGIC_CELL      3'h7
// Instruction clock is the core clock divided by four.
`define INSTR_DIV          4
`endif

//--- hdl/edge_source.v
// Clock source selection, optional synchroniser and rising edge detection.
`timescale 1ns/1ps
`include "timer_counter_map.vh"
module edge_source (
  input  wire       core_clk,
  input  wire       rst,
  input  wire [2:0] clock_source_select,
  input  wire       async_input_select,
  input  wire       instr_tick,
  input  wire       routed_input_pin,
  input  wire       hf_osc_in,
  input  wire       lf_osc_in,
  input  wire       sec_osc_in,
  input  wire       logic_cell_in,
  output reg        src_tick
);
  reg  sel_level;
  reg  sync1_reg;
  reg  sync2_reg;
  reg  prev_reg;
  wire now_level;
  wire sync_edge;

  always @* begin
    case (clock_source_select)
      `CS_PIN_TRUE:   sel_level = routed_input_pin;
      `CS_PIN_INV:    sel_level = ~routed_input_pin;
      `CS_HF_OSC:     sel_level = hf_osc_in;
      `CS_LF_OSC:     sel_level = lf_osc_in;
      `CS_SEC_OSC:    sel_level = sec_osc_in;
      `CS_LOGIC_CELL: sel_level = logic_cell_in;
      default:        sel_level = 1'b0;
    endcase
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
    end else begin
      sync1_reg <= sel_level;
      sync2_reg <= sync1_reg;
      // Sync mode compares levels at successive instruction ticks, so no slow edge is lost.
      if (async_input_select | instr_tick)
        prev_reg <= now_level;
    end
  end

  // Async mode skips the two-stage synchroniser; sync mode edges only count on instruction ticks.
  assign now_level = async_input_select ? sel_level : sync2_reg;
  assign sync_edge = now_level & ~prev_reg;

  always @* begin
    if (clock_source_select == `CS_INSTR)
      src_tick = instr_tick;
    else if (async_input_select)
      src_tick = sync_edge;
    else
      src_tick = sync_edge & instr_tick;
  end
endmodule

//--- hdl/prescaler.v
// Power-of-two prescaler producing one tick per selected number of source ticks.
`timescale 1ns/1ps
module prescaler #(
  parameter WIDTH = 15
) (
  input  wire       core_clk,
  input  wire       rst,
  input  wire       clear,
  input  wire       src_tick,
  input  wire [3:0] prescale_select,
  output reg        pre_tick
);
  reg [WIDTH-1:0] count_reg;
  reg [WIDTH-1:0] mask;
  integer i;

  always @* begin
    for (i = 0; i < WIDTH; i = i + 1)
      mask[i] = (i < prescale_select);
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst)
      count_reg <= {WIDTH{1'b0}};
    else if (clear)
      count_reg <= {WIDTH{1'b0}};
    else if (src_tick)
      count_reg <= (count_reg & mask) == mask ? {WIDTH{1'b0}} : count_reg + 1'b1;
  end

  // Ratio is two to the power of the select field; 0000 passes every tick through.
  always @* begin
    pre_tick = src_tick & ((count_reg & mask) == mask);
  end
endmodule

//--- hdl/timer_counter.v
// Timer/counter top: Avalon-MM registers, 8/16-bit counter, postscaler and output.
// How it works
// - wide_mode_select picks 8-bit or 16-bit counting.
// - Instruction clock source advances the count once per prescaler output, with one source tick per instruction cycle.
// - Other sources advance on their rising edge or prescaler output.
// - Prescaler divides by powers of two from 1 to 32768.
// - 16-bit: reading low count latches true high byte into buffer.
// - 16-bit: writing low count loads high byte from buffer together.
// - 8-bit: match with period clears count, raises an event, copies period.
// - 8-bit: count and period are read/write; reset gives 00 and FF.
// - Low count or control writes and reset clear pre and postscaler.
// - Prescaler and postscaler counts are never readable or writable.
// - Postscaler divides events by 1 to 16.
// - Async select counts raw edges, also during sleep.
// - Sync mode synchronises input and caps rate at instruction clock.
// - Sleep halts sync mode; async keeps counting and may wake.
// - Events are 8-bit period match or 16-bit wrap from FFFF.
// - Flag sets every postscale plus one events.
// - Enabled flag raises interrupt, and wake request during sleep.
// - Output readable as status bit and driven to other logic.
// - Output toggles every postscale plus one events.
// - Three-bit clock source field selects the counter clock.
// - Enable bit runs the module; clear holds it idle.
// - Source codes: pin, inverted pin, instruction clock, oscillators, cell.
//
// Chosen here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "timer_counter_map.vh"
module timer_counter #(
  parameter PRESCALE_WIDTH = 15
) (
  input  wire        core_clk,
  input  wire        rst,
  input  wire [4:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire        sleep_mode,
  input  wire        routed_input_pin,
  input  wire        hf_osc_in,
  input  wire        lf_osc_in,
  input  wire        sec_osc_in,
  input  wire        logic_cell_in,
  output reg         timer_output_signal,
  output reg         irq,
  output reg         wake_req
);
  // ****************************************
  // Registers
  // ****************************************
  reg [7:0]  count_low_reg;
  reg [7:0]  count_high_reg;
  reg [7:0]  high_buffer_period_reg;
  reg [7:0]  period_buffer_reg;
  reg [7:0]  control_reg_zero;
  reg [7:0]  control_reg_one;
  reg        timer_irq_flag_reg;
  reg        timer_irq_enable_reg;
  reg        timer_output_status_reg;
  reg [3:0]  post_count_reg;
  reg [1:0]  instr_div_reg;
  reg        ack_reg;

  wire       timer_enable_bit    = control_reg_zero[`CTRL0_ENABLE_BIT];
  wire       wide_mode_select    = control_reg_zero[`CTRL0_WIDE_BIT];
  wire [3:0] postscale_select    = control_reg_zero[`CTRL0_POST_HI:`CTRL0_POST_LO];
  wire [2:0] clock_source_select = control_reg_one[`CTRL1_CS_HI:`CTRL1_CS_LO];
  wire       async_input_select  = control_reg_one[`CTRL1_ASYNC_BIT];
  wire [3:0] prescale_select     = control_reg_one[`CTRL1_PRE_HI:`CTRL1_PRE_LO];

  // ****************************************
  // Bus decode
  // ****************************************
  wire       req_go  = (avs_read | avs_write) & ~ack_reg;
  wire       wr_go   = req_go & avs_write & avs_byteenable[0];
  wire       rd_go   = req_go & avs_read;
  wire [7:0] wr_byte = avs_writedata[7:0];
  wire       wr_low  = wr_go & (avs_address == `ADDR_COUNT_LOW);
  wire       wr_high = wr_go & (avs_address == `ADDR_HIGH_BUFFER);
  wire       wr_c0   = wr_go & (avs_address == `ADDR_CONTROL_ZERO);
  wire       wr_c1   = wr_go & (avs_address == `ADDR_CONTROL_ONE);
  wire       wr_irq  = wr_go & (avs_address == `ADDR_IRQ);
  wire       rd_low  = rd_go & (avs_address == `ADDR_COUNT_LOW);
  wire       scaler_clear = wr_low | wr_c0 | wr_c1;

  // ****************************************
  // Tick generation
  // ****************************************
  wire instr_tick = (instr_div_reg == 2'h3);
  wire src_tick;
  wire pre_tick;
  // Sync mode freezes in sleep because run masks its ticks; async keeps running.
  wire run = timer_enable_bit & (async_input_select | ~sleep_mode);

  always @(posedge core_clk or posedge rst) begin
    if (rst)
      instr_div_reg <= 2'h0;
    else
      instr_div_reg <= instr_div_reg + 2'h1;
  end

  edge_source u_edge_source (
    .core_clk            (core_clk),
    .rst                 (rst),
    .clock_source_select (clock_source_select),
    .async_input_select  (async_input_select),
    .instr_tick          (instr_tick),
    .routed_input_pin    (routed_input_pin),
    .hf_osc_in           (hf_osc_in),
    .lf_osc_in           (lf_osc_in),
    .sec_osc_in          (sec_osc_in),
    .logic_cell_in       (logic_cell_in),
    .src_tick            (src_tick)
  );

  prescaler #(
    .WIDTH (PRESCALE_WIDTH)
  ) u_prescaler (
    .core_clk        (core_clk),
    .rst             (rst),
    .clear           (scaler_clear),
    .src_tick        (src_tick & run),
    .prescale_select (prescale_select),
    .pre_tick        (pre_tick)
  );

  // ****************************************
  // Counter and events
  // ****************************************
  wire cnt_tick   = pre_tick & run;
  wire match8     = ~wide_mode_select & (count_low_reg == high_buffer_period_reg);
  wire wrap16     = wide_mode_select & (count_low_reg == 8'hff) & (count_high_reg == 8'hff);
  wire event_hit  = cnt_tick & (match8 | wrap16);
  wire post_done  = event_hit & (post_count_reg == postscale_select);

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count_low_reg          <= `RST_COUNT_LOW;
      count_high_reg         <= 8'h00;
      high_buffer_period_reg <= `RST_PERIOD;
      period_buffer_reg      <= `RST_PERIOD;
      control_reg_zero       <= `RST_CONTROL;
      control_reg_one        <= `RST_CONTROL;
      timer_irq_enable_reg   <= 1'b0;
    end else begin
      if (wr_c0)
        control_reg_zero <= wr_byte;
      if (wr_c1)
        control_reg_one <= wr_byte;
      if (wr_irq)
        timer_irq_enable_reg <= wr_byte[`IRQ_ENABLE_BIT];
      if (wr_high)
        high_buffer_period_reg <= wr_byte;
      else if (rd_low & wide_mode_select)
        high_buffer_period_reg <= count_high_reg;
      if (wr_low) begin
        count_low_reg <= wr_byte;
        if (wide_mode_select)
          count_high_reg <= high_buffer_period_reg;
      end else if (cnt_tick) begin
        if (match8) begin
          count_low_reg     <= 8'h00;
          period_buffer_reg <= high_buffer_period_reg;
        end else begin
          count_low_reg <= count_low_reg + 8'h01;
          if (wide_mode_select && count_low_reg == 8'hff)
            count_high_reg <= count_high_reg + 8'h01;
        end
      end
    end
  end

  // ****************************************
  // Postscaler, flag and output
  // ****************************************
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      post_count_reg          <= 4'h0;
      timer_output_status_reg <= 1'b0;
      timer_irq_flag_reg      <= 1'b0;
    end else begin
      if (scaler_clear)
        post_count_reg <= 4'h0;
      else if (post_done)
        post_count_reg <= 4'h0;
      else if (event_hit)
        post_count_reg <= post_count_reg + 4'h1;
      if (post_done)
        timer_output_status_reg <= ~timer_output_status_reg;
      // A flag event in the clearing cycle wins over the clear.
      if (post_done)
        timer_irq_flag_reg <= 1'b1;
      else if (wr_irq && !wr_byte[`IRQ_FLAG_BIT])
        timer_irq_flag_reg <= 1'b0;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      timer_output_signal <= 1'b0;
      irq                 <= 1'b0;
      wake_req            <= 1'b0;
    end else begin
      timer_output_signal <= timer_output_status_reg;
      irq                 <= timer_irq_flag_reg & timer_irq_enable_reg;
      wake_req            <= timer_irq_flag_reg & timer_irq_enable_reg & sleep_mode;
    end
  end

  // ****************************************
  // Bus answer
  // ****************************************
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_reg         <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      ack_reg         <= req_go;
      avs_waitrequest <= ~req_go;
      if (rd_go) begin
        case (avs_address)
          `ADDR_COUNT_LOW:            avs_readdata <= {24'h0, count_low_reg};
          `ADDR_HIGH_BUFFER:          avs_readdata <= {24'h0, high_buffer_period_reg};
          `ADDR_CONTROL_ZERO:         avs_readdata <= {24'h0, timer_enable_bit, 1'b0,
                                                     timer_output_status_reg, wide_mode_select,
                                                     postscale_select};
          `ADDR_CONTROL_ONE:          avs_readdata <= {24'h0, control_reg_one};
          `ADDR_IRQ:                  avs_readdata <= {30'h0, timer_irq_enable_reg,
                                                     timer_irq_flag_reg};
          default:                    avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

//--- test/timer_counter_checker.sv
// Concurrent checks on the ports of the timer/counter.
`timescale 1ns/1ps
module timer_counter_checker #(
  parameter PRESCALE_WIDTH = 15
) (
  input wire        core_clk,
  input wire        rst,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        sleep_mode,
  input wire        timer_output_signal,
  input wire        irq,
  input wire        wake_req
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_answer_one_cycle: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("answer not one cycle after request");
  a_answer_lasts_one: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  a_answer_has_cause: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
    else $error("answer without request");
  a_readdata_upper_zero: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  a_readdata_holds: assert property (!avs_read && !$past(avs_read) |-> $stable(avs_readdata))
    else $error("read data changed without read");
  a_irq_fall_write: assert property ($fell(irq) |-> $past(avs_write, 2) || $past(avs_write, 3))
    else $error("interrupt dropped without write");
  a_wake_needs_irq: assert property (wake_req |-> irq)
    else $error("wake request without interrupt");
  a_wake_in_sleep: assert property ($rose(wake_req) |-> $past(sleep_mode))
    else $error("wake request while awake");
  a_output_spacing: assert property ($changed(timer_output_signal) |=> $stable(timer_output_signal))
    else $error("output toggled on consecutive cycles");
endmodule
bind timer_counter timer_counter_checker #(.PRESCALE_WIDTH(PRESCALE_WIDTH)) u_chk (
  .core_clk(core_clk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sleep_mode(sleep_mode),
  .timer_output_signal(timer_output_signal), .irq(irq), .wake_req(wake_req));

//--- test/timer_counter_test.sv
// Self-checking testbench of the timer/counter.
`timescale 1ns/1ps
`include "timer_counter_map.vh"
module timer_counter_test;
  logic        core_clk, rst, avs_read, avs_write, avs_waitrequest, sleep_mode, pin;
  logic        timer_output_signal, irq, wake_req;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0]  avs_byteenable;
  int          err_total, comparisons, n;
  int          post_t[3] = '{0, 3, 1};
  int          pre_t[3]  = '{0, 0, 2};
  int          per_t[3]  = '{3, 3, 5};
  logic [2:0]  src_t[7]  = '{`CS_PIN_TRUE, `CS_PIN_INV, `CS_HF_OSC, `CS_LF_OSC,
                             `CS_RESERVED, `CS_SEC_OSC, `CS_LOGIC_CELL};
  logic [4:0]  adr_t[5]  = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h14};
  logic [7:0]  rv_t[5]   = '{`RST_COUNT_LOW, `RST_PERIOD, `RST_CONTROL, `RST_CONTROL, 8'h00};
  timer_counter u_timer_counter (
    .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sleep_mode(sleep_mode),
    .routed_input_pin(pin), .hf_osc_in(pin), .lf_osc_in(pin), .sec_osc_in(pin),
    .logic_cell_in(pin), .timer_output_signal(timer_output_signal), .irq(irq),
    .wake_req(wake_req));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // ************************************************************
  // Bus access, comparison, toggle wait, pin pulse and closing tasks.
  // ************************************************************
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_toggle(output int c);
    logic prev;
    prev = timer_output_signal;
    c = 0;
    do begin
      @(posedge core_clk);
      c++;
    end while (timer_output_signal === prev && c < 4000);
    if (c >= 4000) err_total++;
  endtask
  task automatic pulse(input int cnt);
    repeat (cnt) begin
      pin <= 1'b1;
      repeat (4) @(posedge core_clk);
      pin <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #(20 * 40000);
    err_total++;
    stop_test;
  end
  // ************************************************************
  // Test sequence.
  // ************************************************************
  initial begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    sleep_mode = 1'b0;
    pin = 1'b0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, adr_t[i], 8'h00);
      chk("reset_value", q, {24'h0, rv_t[i]});
    end
    bus(1'b1, 5'h10, 8'h02);
    // Instruction clock timing: output gap is (post+1) x (period+1) x divider x prescale.
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, `ADDR_HIGH_BUFFER, per_t[i][7:0]);
      bus(1'b1, `ADDR_CONTROL_ONE, {`CS_INSTR, 1'b0, pre_t[i][3:0]});
      bus(1'b1, `ADDR_CONTROL_ZERO, 8'h80 | post_t[i][7:0]);
      wait_toggle(n);
      wait_toggle(n);
      chk("toggle_gap", n, (post_t[i] + 1) * (per_t[i] + 1) * `INSTR_DIV << pre_t[i]);
      chk("irq", irq, 1'b1);
      bus(1'b0, 5'h10, 8'h00);
      chk("flag", q[0], 1'b1);
    end
    // Sixteen-bit load through the high buffer.
    bus(1'b1, `ADDR_CONTROL_ZERO, 8'h10);
    bus(1'b1, `ADDR_HIGH_BUFFER, 8'h12);
    bus(1'b1, `ADDR_COUNT_LOW, 8'h34);
    bus(1'b1, `ADDR_HIGH_BUFFER, 8'h56);
    bus(1'b0, `ADDR_HIGH_BUFFER, 8'h00);
    chk("buffer", q, 32'h56);
    bus(1'b0, `ADDR_COUNT_LOW, 8'h00);
    chk("count_low16", q, 32'h34);
    bus(1'b0, `ADDR_HIGH_BUFFER, 8'h00);
    chk("count_high16", q, 32'h12);
    // Counter mode on every source except the instruction clock, with asynchronous input.
    for (int i = 0; i < 7; i++) begin
      bus(1'b1, `ADDR_CONTROL_ZERO, 8'h00);
      bus(1'b1, `ADDR_HIGH_BUFFER, 8'hff);
      bus(1'b1, `ADDR_CONTROL_ONE, {src_t[i], 5'h10});
      bus(1'b1, `ADDR_CONTROL_ZERO, 8'h80);
      bus(1'b1, `ADDR_COUNT_LOW, 8'h00);
      pulse(5);
      bus(1'b0, `ADDR_COUNT_LOW, 8'h00);
      chk("edge_count", q, (src_t[i] == `CS_RESERVED) ? 32'h0 : 32'h5);
    end
    // Synchronous mode counts every slow edge while awake and halts in sleep.
    bus(1'b1, `ADDR_CONTROL_ONE, 8'h00);
    bus(1'b1, `ADDR_COUNT_LOW, 8'h00);
    pulse(5);
    bus(1'b0, `ADDR_COUNT_LOW, 8'h00);
    chk("sync_count", q, 32'h5);
    sleep_mode <= 1'b1;
    bus(1'b1, `ADDR_COUNT_LOW, 8'h00);
    pulse(5);
    bus(1'b0, `ADDR_COUNT_LOW, 8'h00);
    chk("sleep_sync", q, 32'h0);
    // Asynchronous sixteen-bit rollover in sleep wakes the device.
    bus(1'b1, `ADDR_CONTROL_ZERO, 8'h10);
    bus(1'b1, `ADDR_CONTROL_ONE, 8'h10);
    bus(1'b1, 5'h10, 8'h02);
    bus(1'b1, `ADDR_HIGH_BUFFER, 8'hff);
    bus(1'b1, `ADDR_COUNT_LOW, 8'hfe);
    bus(1'b1, `ADDR_CONTROL_ZERO, 8'h90);
    chk("irq_idle", irq, 1'b0);
    pulse(2);
    chk("irq_wrap", irq, 1'b1);
    chk("wake", wake_req, 1'b1);
    bus(1'b0, `ADDR_COUNT_LOW, 8'h00);
    chk("wrap_low", q, 32'h0);
    bus(1'b0, `ADDR_HIGH_BUFFER, 8'h00);
    chk("wrap_high", q, 32'h0);
    bus(1'b1, 5'h10, 8'h00);
    repeat (3) @(posedge core_clk);
    chk("irq_clear", irq, 1'b0);
    stop_test;
  end
endmodule
